// *** ospc_host.sv ***
// Host serial controller model that drives command frames on the link in mode 0.
`timescale 1ns/1ps
module ospc_host (
  // Link pins.
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // The link clock stays low and select stays high between frames.
  initial
  begin
    sclk = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
  end

  // Shifts n bits of tx MSB first and collects the output; a floating output reads as z.
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '1;
    #50 cs_n = 1'h0;
    for (int i = 0; i < n; i++)
    begin
      mosi = tx[63 - i];
      #62.5 sclk = 1'h1;
      rx = {rx[62:0], miso_oe ? miso_o : 1'bz};
      #62.5 sclk = 1'h0;
    end
    // Release comes right after the last bit, so a whole-byte frame ends on its boundary.
    #60 cs_n = 1'h1;
    mosi = ~mosi;
  endtask
endmodule

// *** ospc_pkg.sv ***
// Shared constants, types and helper functions of the security page command handler.
package ospc_pkg;
  // Command opcodes accepted on the serial link.
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_STAT1 = 8'h05;
  localparam logic [7:0] OP_STAT2 = 8'h35;
  localparam logic [7:0] OP_ERASE = 8'h44;
  localparam logic [7:0] OP_PROG = 8'h42;
  localparam logic [7:0] OP_READ = 8'h48;

  // Frame bit counts at which the command phases end.
  localparam logic [15:0] BITS_ONE = 16'h0001;
  localparam logic [15:0] BITS_MAX = 16'hFFFF;
  localparam logic [15:0] BITS_OPCODE = 16'h0008;
  localparam logic [15:0] BITS_ADDR_END = 16'h0020;
  localparam logic [15:0] BITS_DUMMY_END = 16'h0028;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Byte positions inside a frame.
  localparam logic [12:0] IDX_OPCODE = 13'h0000;
  localparam logic [12:0] IDX_ADDR_HI = 13'h0001;
  localparam logic [12:0] IDX_ADDR_MID = 13'h0002;
  localparam logic [12:0] IDX_ADDR_LO = 13'h0003;
  localparam logic [12:0] IDX_DATA = 13'h0004;

  // Page geometry and address decode.
  localparam int NUM_PAGES = 3;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ADDR_TOP_SEC = 8'h00;
  localparam logic [7:0] PAGE_FIRST = 8'h01;
  localparam logic [7:0] PAGE_LAST = 8'h03;
  localparam logic [7:0] OFF_ZERO = 8'h00;
  localparam logic [7:0] OFF_STEP = 8'h01;
  localparam logic [7:0] OFF_LAST = 8'hFF;
  localparam logic [1:0] PAGE_BASE = 2'h1;

  // Timing of the self-timed operations.
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam logic [31:0] TIMER_ONE = 32'h0000_0001;

  // Internal operation states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b10
  } ospc_state_t;

  // True when the address names one of the three security pages.
  function automatic logic page_ok(input logic [23:0] a);
    return (a[23:16] == ADDR_TOP_SEC) && (a[15:8] >= PAGE_FIRST) && (a[15:8] <= PAGE_LAST);
  endfunction

  // Zero-based page index of a valid security address.
  function automatic logic [1:0] page_sel(input logic [23:0] a);
    return 2'(a[9:8] - PAGE_BASE);
  endfunction

  // Whole system clock cycles in a time in microseconds, never less than one.
  function automatic logic [31:0] us_to_cycles(input int us);
    int c;
    c = us * NS_PER_US / CLK_PERIOD_NS;
    return (c < 1) ? TIMER_ONE : 32'(c);
  endfunction
endpackage

// *** ospc_sync.sv ***
// Two flip-flop level synchroniser with a constant reset value.
`timescale 1ns/1ps
module ospc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Destination clock domain.
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // Level to carry across and its synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage to let metastability settle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else if (en)
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// *** ospc_top.sv ***
// Command handler for three security pages with one-time-programmable locks behind a serial link.
`timescale 1ns/1ps
module ospc_top #(
  parameter int ERASE_TIME_US = 1000,
  parameter int PROG_TIME_US = 100
) (
  // System clock domain.
  input wire logic clk,
  input wire logic clk_en,
  input wire logic sys_rst,
  // Serial link driven by the host.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  // Lock programming and status.
  input wire logic [2:0] lock_set,
  output logic ready_busy_flag,
  output logic write_enable_latch,
  output logic [2:0] page_lock_bits
);
  localparam logic [31:0] ERASE_CYCLES = ospc_pkg::us_to_cycles(ERASE_TIME_US);
  localparam logic [31:0] PROG_CYCLES = ospc_pkg::us_to_cycles(PROG_TIME_US);

  // Link domain state.
  logic link_rst;
  logic frame_new_q;
  logic [15:0] bits_q;
  logic [15:0] bits_d;
  logic [7:0] shift_q;
  logic [7:0] byte_d;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [2:0] bit_pos;
  logic byte_done;
  logic [12:0] byte_idx;
  logic [7:0] buf_q [ospc_pkg::PAGE_BYTES];
  logic [ospc_pkg::PAGE_BYTES-1:0] mask_q;
  logic [7:0] wr_ptr_q;
  logic [7:0] rd_off_q;
  logic [7:0] rd_off_w;
  logic out_read;
  logic out_stat;
  logic tx_load;
  logic [7:0] rd_byte;
  logic [7:0] tx_byte;
  logic [4:0] stat_s;
  logic [7:0] stat1_s;
  logic [7:0] stat2_s;

  // System domain state.
  logic cs_s;
  logic cs_prev_q;
  logic end_w;
  ospc_pkg::ospc_state_t state_q;
  logic [31:0] timer_q;
  logic [1:0] page_q;
  logic latch_q;
  logic [2:0] locks_q;
  logic [3:0] lock_ext;
  logic [7:0] mem_q [ospc_pkg::NUM_PAGES][ospc_pkg::PAGE_BYTES];
  logic idle_w;
  logic on_byte;
  logic tgt_ok;
  logic wren_w;
  logic wrdi_w;
  logic erase_go_w;
  logic prog_go_w;
  logic abort_w;
  logic commit_w;

  // The frame flag, read offset and output stage are held in reset whenever select is high, so each frame starts clean.
  assign link_rst = sys_rst | cs_n;

  // Marks the first rising link edge of a frame; frame fields survive select release.
  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
      frame_new_q <= 1'b1;
    else
      frame_new_q <= 1'b0;
  end

  // Bit position and the byte completing on this edge.
  assign bit_pos = frame_new_q ? ospc_pkg::BIT_FIRST : bits_q[2:0];
  assign byte_done = (bit_pos == ospc_pkg::BIT_LAST);
  assign byte_idx = frame_new_q ? ospc_pkg::IDX_OPCODE : bits_q[15:3];
  assign byte_d = {(frame_new_q ? 7'h00 : shift_q[6:0]), mosi};
  assign bits_d = frame_new_q ? ospc_pkg::BITS_ONE :
                  (bits_q == ospc_pkg::BITS_MAX) ? bits_q : bits_q + ospc_pkg::BITS_ONE;

  // Opcode and address capture on rising link edges.
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bits_q <= '0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
    end
    else
    begin
      bits_q <= bits_d;
      shift_q <= byte_d;
      if (byte_done)
      begin
        unique case (byte_idx)
          ospc_pkg::IDX_OPCODE: opcode_q <= byte_d;
          ospc_pkg::IDX_ADDR_HI: addr_q[23:16] <= byte_d;
          ospc_pkg::IDX_ADDR_MID: addr_q[15:8] <= byte_d;
          ospc_pkg::IDX_ADDR_LO: addr_q[7:0] <= byte_d;
          default: addr_q <= addr_q;
        endcase
      end
    end
  end

  // Program buffer: cleared by the opcode, then filled from the start byte with page wrap.
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int b = 0; b < ospc_pkg::PAGE_BYTES; b++)
        buf_q[b] <= ospc_pkg::ERASED_BYTE;
      mask_q <= '0;
      wr_ptr_q <= ospc_pkg::OFF_ZERO;
    end
    else if (byte_done)
    begin
      if (byte_idx == ospc_pkg::IDX_OPCODE && byte_d == ospc_pkg::OP_PROG)
        mask_q <= '0;
      else if (byte_idx == ospc_pkg::IDX_ADDR_LO)
        wr_ptr_q <= byte_d;
      else if (opcode_q == ospc_pkg::OP_PROG && byte_idx >= ospc_pkg::IDX_DATA)
      begin
        buf_q[wr_ptr_q] <= byte_d;
        mask_q[wr_ptr_q] <= 1'b1;
        wr_ptr_q <= wr_ptr_q + ospc_pkg::OFF_STEP;
      end
    end
  end

  // Status bits cross into the link domain; a frame sees them two link edges late.
  ospc_sync #(
    .W(5),
    .RST_VAL(5'h00)
  ) u_stat_sync (
    .clk(sclk),
    .rst(sys_rst),
    .en(1'b1),
    .d({locks_q, latch_q, ready_busy_flag}),
    .q(stat_s)
  );

  // Status byte images.
  assign stat1_s = {6'h00, stat_s[1], stat_s[0]};
  assign stat2_s = {2'h0, stat_s[4:2], 3'h0};

  // Output phases: read data after the dummy byte, status after the opcode.
  assign out_read = !frame_new_q && opcode_q == ospc_pkg::OP_READ &&
                    bits_q >= ospc_pkg::BITS_DUMMY_END;
  assign out_stat = !frame_new_q && bits_q >= ospc_pkg::BITS_OPCODE &&
                    (opcode_q == ospc_pkg::OP_STAT1 || opcode_q == ospc_pkg::OP_STAT2);
  assign tx_load = (bits_q[2:0] == ospc_pkg::BIT_FIRST);
  assign rd_off_w = (bits_q == ospc_pkg::BITS_DUMMY_END) ? addr_q[7:0] : rd_off_q;

  // Pages only change while busy, and reads then return erased bytes instead.
  always_comb
  begin
    if (!ospc_pkg::page_ok(addr_q) || stat_s[0])
      rd_byte = ospc_pkg::ERASED_BYTE;
    else
      rd_byte = mem_q[ospc_pkg::page_sel(addr_q)][rd_off_w];
    if (out_read)
      tx_byte = rd_byte;
    else if (opcode_q == ospc_pkg::OP_STAT1)
      tx_byte = stat1_s;
    else
      tx_byte = stat2_s;
  end

  // Read offset advances per byte; eight-bit wrap gives a gapless return to byte zero.
  always_ff @(negedge sclk or posedge link_rst)
  begin
    if (link_rst)
      rd_off_q <= ospc_pkg::OFF_ZERO;
    else if (out_read && tx_load)
      rd_off_q <= rd_off_w + ospc_pkg::OFF_STEP;
  end

  // Serial output stage.
  ospc_tx u_tx (
    .sclk(sclk),
    .link_rst(link_rst),
    .active(out_read | out_stat),
    .load(tx_load),
    .src(tx_byte),
    .miso_o(miso_o),
    .miso_oe(miso_oe)
  );

  // Select is synchronised so that its rising edge ends the frame in this domain.
  ospc_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_cs_sync (
    .clk(clk),
    .rst(sys_rst),
    .en(clk_en),
    .d(cs_n),
    .q(cs_s)
  );

  // Edge memory for the synchronised select.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cs_prev_q <= 1'b1;
    else if (clk_en)
      cs_prev_q <= cs_s;
  end

  // Frame decode; frame fields are static here because the link clock has stopped.
  assign end_w = clk_en && cs_s && !cs_prev_q;
  assign idle_w = (state_q == ospc_pkg::ST_IDLE);
  assign on_byte = (bits_q[2:0] == ospc_pkg::BIT_FIRST) && (bits_q >= ospc_pkg::BITS_OPCODE);
  assign lock_ext = {locks_q, 1'b0};
  assign tgt_ok = ospc_pkg::page_ok(addr_q) && !lock_ext[addr_q[9:8]];
  assign wren_w = end_w && idle_w && opcode_q == ospc_pkg::OP_WR_EN && on_byte;
  assign wrdi_w = end_w && idle_w && opcode_q == ospc_pkg::OP_WR_DIS && on_byte;
  assign erase_go_w = end_w && idle_w && opcode_q == ospc_pkg::OP_ERASE && latch_q &&
                      bits_q == ospc_pkg::BITS_ADDR_END && tgt_ok;
  assign prog_go_w = end_w && idle_w && opcode_q == ospc_pkg::OP_PROG && latch_q && on_byte &&
                     bits_q > ospc_pkg::BITS_ADDR_END && tgt_ok;
  assign abort_w = end_w && idle_w && latch_q &&
                   ((opcode_q == ospc_pkg::OP_ERASE && !erase_go_w) ||
                    (opcode_q == ospc_pkg::OP_PROG && !prog_go_w));
  assign commit_w = clk_en && !idle_w && timer_q == ospc_pkg::TIMER_ONE;

  // Self-timed operation sequencer on the system clock.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ospc_pkg::ST_IDLE;
      timer_q <= '0;
      page_q <= 2'h0;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        ospc_pkg::ST_IDLE:
        begin
          page_q <= ospc_pkg::page_sel(addr_q);
          if (erase_go_w)
          begin
            state_q <= ospc_pkg::ST_ERASE;
            timer_q <= ERASE_CYCLES;
          end
          else if (prog_go_w)
          begin
            state_q <= ospc_pkg::ST_PROG;
            timer_q <= PROG_CYCLES;
          end
        end
        ospc_pkg::ST_ERASE, ospc_pkg::ST_PROG:
        begin
          if (commit_w)
            state_q <= ospc_pkg::ST_IDLE;
          else
            timer_q <= timer_q - ospc_pkg::TIMER_ONE;
        end
        default: state_q <= ospc_pkg::ST_IDLE;
      endcase
    end
  end

  // Busy shows the sequencer; it falls on the commit edge of the operation.
  assign ready_busy_flag = !idle_w;

  // Page storage: each page is written only by its own erase or program commit.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int p = 0; p < ospc_pkg::NUM_PAGES; p++)
        for (int b = 0; b < ospc_pkg::PAGE_BYTES; b++)
          mem_q[p][b] <= ospc_pkg::ERASED_BYTE;
    end
    else if (commit_w)
    begin
      for (int b = 0; b < ospc_pkg::PAGE_BYTES; b++)
      begin
        if (state_q == ospc_pkg::ST_ERASE)
          mem_q[page_q][b] <= ospc_pkg::ERASED_BYTE;
        else if (mask_q[b])
          mem_q[page_q][b] <= mem_q[page_q][b] & buf_q[b]; // Programming only clears bits.
      end
    end
  end

  // Write enable latch; a set and a clear never come from the same frame.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      latch_q <= 1'b0;
    else if (clk_en)
    begin
      if (wren_w)
        latch_q <= 1'b1;
      else if (wrdi_w || abort_w || commit_w)
        latch_q <= 1'b0;
    end
  end

  // Lock bits only ever accumulate ones.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      locks_q <= 3'h0;
    else if (clk_en)
      locks_q <= locks_q | lock_set;
  end

  assign write_enable_latch = latch_q;
  assign page_lock_bits = locks_q;

  AST_ERASE_NEEDS_LATCH: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ospc_pkg::ST_IDLE ##1 state_q == ospc_pkg::ST_ERASE) |-> $past(latch_q))
    else $error("Erase started without the write enable latch.");

  AST_PROG_NEEDS_LATCH: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ospc_pkg::ST_IDLE ##1 state_q == ospc_pkg::ST_PROG) |-> $past(latch_q))
    else $error("Program started without the write enable latch.");

  AST_SHORT_ERASE_ABORTS: assert property (@(posedge clk) disable iff (sys_rst)
    (end_w && idle_w && opcode_q == ospc_pkg::OP_ERASE && bits_q != ospc_pkg::BITS_ADDR_END)
    |=> (state_q == ospc_pkg::ST_IDLE && !latch_q))
    else $error("Malformed erase frame was not aborted.");

  AST_LOCKED_IGNORED: assert property (@(posedge clk) disable iff (sys_rst)
    (end_w && idle_w && opcode_q == ospc_pkg::OP_ERASE && ospc_pkg::page_ok(addr_q) &&
     lock_ext[addr_q[9:8]]) |=> state_q == ospc_pkg::ST_IDLE)
    else $error("Erase of a locked page was started.");

  AST_ERASE_TIME: assert property (@(posedge clk) disable iff (sys_rst)
    erase_go_w |=> (timer_q == ERASE_CYCLES && ready_busy_flag))
    else $error("Erase did not load its full self-timed count.");

  AST_BUSY_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
    commit_w |=> (!ready_busy_flag && !latch_q))
    else $error("Busy or latch still set after commit.");

  AST_LOCK_OTP: assert property (@(posedge clk) disable iff (sys_rst)
    (page_lock_bits & $past(page_lock_bits)) == $past(page_lock_bits))
    else $error("A set lock bit was cleared.");

  AST_ERASE_FILLS: assert property (@(posedge clk) disable iff (sys_rst)
    (commit_w && state_q == ospc_pkg::ST_ERASE) |=>
    (mem_q[page_q][ospc_pkg::OFF_ZERO] == ospc_pkg::ERASED_BYTE &&
     mem_q[page_q][ospc_pkg::OFF_LAST] == ospc_pkg::ERASED_BYTE))
    else $error("Erased page is not blank.");

  AST_LATCH_BOUNDARY: assert property (@(posedge clk) disable iff (sys_rst)
    (end_w && opcode_q == ospc_pkg::OP_WR_EN && bits_q[2:0] != ospc_pkg::BIT_FIRST)
    |=> $stable(latch_q))
    else $error("Latch changed on an unaligned enable frame.");

  AST_HIZ_OFF_FRAME: assert property (@(posedge clk) disable iff (sys_rst)
    cs_n |-> !miso_oe)
    else $error("Output driven while select is high.");

  AST_BUF_OVERWRITE: assert property (@(posedge sclk) disable iff (sys_rst)
    (byte_done && byte_idx == ospc_pkg::IDX_OPCODE && byte_d == ospc_pkg::OP_PROG)
    |=> mask_q == '0)
    else $error("Program opcode did not discard the buffer.");

  AST_READ_WRAP: assert property (@(negedge sclk) disable iff (link_rst)
    (out_read && tx_load && rd_off_w == ospc_pkg::OFF_LAST) |=> rd_off_q == ospc_pkg::OFF_ZERO)
    else $error("Read did not wrap to the first byte.");
endmodule

// *** ospc_top_bench.sv ***
// Self-checking testbench for the security page command handler.
`timescale 1ns/1ps
module ospc_top_bench;
  // System side stimulus and observed outputs.
  logic clk;
  logic sys_rst;
  logic clk_en;
  logic [2:0] lock_set;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic ready_busy_flag;
  logic write_enable_latch;
  logic [2:0] page_lock_bits;
  logic [63:0] rx;
  int miscompares;
  int samples_checked;

  // Short operation times keep busy periods at 200 and 100 cycles.
  ospc_top #(.ERASE_TIME_US(2), .PROG_TIME_US(1)) dut_u (
    .clk(clk), .clk_en(clk_en), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .lock_set(lock_set), .ready_busy_flag(ready_busy_flag),
    .write_enable_latch(write_enable_latch), .page_lock_bits(page_lock_bits)
  );

  ospc_host host_u (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe)
  );

  // The system clock runs at 100 MHz.
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Compares one result and counts it.
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Polls the busy flag and measures how long it stands; zero means nothing may start.
  task automatic run(input int len);
    int w;
    int c;
    w = 0;
    c = 0;
    while (ready_busy_flag !== 1'h1 && w < 20)
    begin
      @(negedge clk);
      w++;
    end
    while (ready_busy_flag === 1'h1 && c < 1000)
    begin
      @(negedge clk);
      c++;
    end
    chk("busy cycles", 24'(len), 24'(c));
    if (c == 1000 || (w == 20 && len > 0))
      complete_run();
  endtask

  // One frame, then the busy check and a check that the output floats once select is high.
  task automatic cmd(input logic [63:0] tx, input int n, input int len);
    host_u.xfer(tx, n, rx);
    run(len);
    chk("output enable", 24'h0, 24'(miso_oe));
  endtask

  // The latch is checked after frames that may move it, except the two program frames at address 000210.
  task automatic chk_latch(input logic e);
    chk("write enable", 24'(e), 24'(write_enable_latch));
  endtask

  task automatic wen();
    cmd({ospc_pkg::OP_WR_EN, 56'h0}, 8, 0);
    chk_latch(1'h1);
  endtask

  // A hang anywhere is cut short here and counted as a mismatch; the limit keeps the run short.
  initial
  begin
    #600us;
    miscompares++;
    complete_run();
  end

  // Main sequence of command frames with expected results.
  initial
  begin
    sys_rst = 1'h1;
    clk_en = 1'h1;
    lock_set = 3'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (10) @(negedge clk);
    sys_rst = 1'h0;
    repeat (5) @(negedge clk);
    chk("reset flags", 24'h0, 24'({ready_busy_flag, write_enable_latch, page_lock_bits}));
    wen();
    cmd({ospc_pkg::OP_STAT1, 56'h0}, 16, 0);
    chk("status one", 24'h02, 24'(rx[7:0]));
    // One bit past the address aborts the erase and drops the latch.
    cmd({ospc_pkg::OP_ERASE, 24'h000100, 32'h0}, 33, 0);
    chk_latch(1'h0);
    cmd({ospc_pkg::OP_ERASE, 24'h000100, 32'h0}, 32, 0);
    // Program at the last offset so the second byte wraps to offset zero.
    wen();
    cmd({ospc_pkg::OP_PROG, 24'h0001FF, 16'h3C96, 16'h0}, 48, 100);
    chk_latch(1'h0);
    cmd({ospc_pkg::OP_READ, 24'h0001FF, 32'h0}, 64, 0);
    chk("read wrap", 24'h3C96FF, rx[23:0]);
    // Erase with a nonzero low byte still clears the whole page.
    wen();
    cmd({ospc_pkg::OP_ERASE, 24'h000177, 32'h0}, 32, 200);
    chk_latch(1'h0);
    cmd({ospc_pkg::OP_READ, 24'h0001FF, 32'h0}, 64, 0);
    chk("erased page", 24'hFFFFFF, rx[23:0]);
    wen();
    cmd({ospc_pkg::OP_PROG, 24'h000210, 8'h5A, 24'h0}, 40, 100);
    wen();
    cmd({ospc_pkg::OP_ERASE, 24'h000400, 32'h0}, 32, 0);
    chk_latch(1'h0);
    // Lock page two with a one-cycle pulse; the bit must stick afterwards.
    lock_set = 3'h2;
    @(negedge clk);
    lock_set = 3'h0;
    repeat (4) @(negedge clk);
    chk("locks", 24'h2, 24'(page_lock_bits));
    // A lock pulse while the clock enable is low must leave the lock bits frozen.
    clk_en = 1'h0;
    lock_set = 3'h4;
    @(negedge clk);
    lock_set = 3'h0;
    clk_en = 1'h1;
    repeat (2) @(negedge clk);
    chk("frozen locks", 24'h2, 24'(page_lock_bits));
    cmd({ospc_pkg::OP_STAT2, 56'h0}, 16, 0);
    chk("status two", 24'h10, 24'(rx[7:0]));
    wen();
    cmd({ospc_pkg::OP_ERASE, 24'h000200, 32'h0}, 32, 0);
    chk_latch(1'h0);
    wen();
    cmd({ospc_pkg::OP_PROG, 24'h000210, 8'h00, 24'h0}, 40, 0);
    cmd({ospc_pkg::OP_READ, 24'h000210, 32'h0}, 64, 0);
    chk("locked page", 24'h5AFFFF, rx[23:0]);
    // The disable opcode drops the latch; an enable released off a byte boundary is ignored.
    wen();
    cmd({ospc_pkg::OP_WR_DIS, 56'h0}, 8, 0);
    chk_latch(1'h0);
    cmd({ospc_pkg::OP_WR_EN, 56'h0}, 9, 0);
    chk_latch(1'h0);
    // A read cut off in mid-byte still floats the output at once.
    cmd({ospc_pkg::OP_READ, 24'h000210, 32'h0}, 44, 0);
    chk("part byte", 24'h5, 24'(rx[3:0]));
    chk("locks kept", 24'h2, 24'(page_lock_bits));
    complete_run();
  end
endmodule

// *** ospc_tx.sv ***
// Falling-edge serialiser that drives the serial data output during a frame.
`timescale 1ns/1ps
module ospc_tx (
  // Link clock and frame reset.
  input wire logic sclk,
  input wire logic link_rst,
  // Byte source.
  input wire logic active,
  input wire logic load,
  input wire logic [7:0] src,
  // Serial output pin.
  output logic miso_o,
  output logic miso_oe
);
  logic [6:0] rest_q;

  // The frame reset drops the enable at once, so the pin floats as soon as select rises.
  always_ff @(negedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      miso_oe <= 1'b0;
      miso_o <= 1'b0;
      rest_q <= 7'h00;
    end
    else if (active)
    begin
      miso_oe <= 1'b1;
      if (load)
      begin
        miso_o <= src[7];
        rest_q <= src[6:0];
      end
      else
      begin
        miso_o <= rest_q[6];
        rest_q <= {rest_q[5:0], 1'b0};
      end
    end
  end
endmodule
